// file: verilog/hsw_pkg.sv
// Package with timing and threshold constants for the duty-cycled field switch
`default_nettype none
package hsw_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    // Operating phase, standby phase and start-up, in their own units
    localparam int unsigned OPERATE_INTERVAL_US = 50;
    localparam int unsigned STANDBY_MS = 130;
    localparam int unsigned STARTUP_US = 6;
    localparam int unsigned STARTUP_WINDOW_US = 12;
    // Derived cycle counts at the core clock rate
    localparam int unsigned OPERATE_CYC = OPERATE_INTERVAL_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned STANDBY_CYC = STANDBY_MS * 1000 * (1000 / CLK_PERIOD_NS);
    localparam int unsigned STARTUP_CYC = (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_WIN_CYC = STARTUP_WINDOW_US * 1000 / CLK_PERIOD_NS;
    // Field magnitude thresholds in tenths of a millitesla
    localparam int unsigned FIELD_W = 8;
    localparam logic [7:0] THR_HIGH = 8'h32;
    localparam logic [7:0] THR_LOW = 8'h28;
    // Sequencer phases
    typedef enum logic [1:0]
    {
        HSW_STANDBY = 2'b00,
        HSW_STARTUP = 2'b01,
        HSW_SOUTH = 2'b10,
        HSW_NORTH = 2'b11
    } hsw_phase_t;
endpackage : hsw_pkg
`default_nettype wire

// file: verilog/hsw_field_switch.sv
// Duty-cycled omnipolar field switch sequencer, comparator logic and open-drain output
//
// Function
// - An internal counter runs a 50 us operating phase then a 130 ms standby phase, forever.
// - After the first decision, the switch output changes only at the end of an operating phase.
// - During standby the output stays latched at the last decided value.
// - Thresholds are checked one after the other, south then north, and latched at standby entry.
// - Either a south or a north field beyond the operate point turns the switch on.
// - With the strap high the output is high at zero field and low once operated.
// - With the strap low the output is inverted, low at zero field and high with field.
// - Hysteresis uses a 5 mT operate and a 4 mT release level, the same for either strap setting.
// - Supply ready within 12 us gives a valid output after the first phase, else the second.
// - The operating phase begins with a 6 us start-up before any comparison.
// - In the high, off state the pull-down is not enabled.
`default_nettype none
module hsw_field_switch
    import hsw_pkg::*;
#(
    parameter int unsigned OPERATE_CYCLES = hsw_pkg::OPERATE_CYC,
    parameter int unsigned STANDBY_CYCLES = hsw_pkg::STANDBY_CYC,
    parameter int unsigned STARTUP_CYCLES = hsw_pkg::STARTUP_CYC,
    parameter int unsigned STARTUP_WIN_CYCLES = hsw_pkg::STARTUP_WIN_CYC
)
(
    input wire logic i_core_clk,                        // Core clock, 50 MHz
    input wire logic i_sys_rst,                         // Async reset, active high
    input wire logic i_polarity_strap,                  // Output polarity strap
    input wire logic i_supply_ok,                       // Supply has reached level
    input wire logic [hsw_pkg::FIELD_W-1:0] i_south_field, // South field magnitude
    input wire logic [hsw_pkg::FIELD_W-1:0] i_north_field, // North field magnitude
    output logic o_out_oe,                              // Pull-down enable, high drives low
    output logic o_out_level,                           // Logical output level
    output logic o_out_valid,                           // Output carries a valid decision
    output logic o_sensing                              // Operating phase active
);
    import hsw_pkg::*;

    localparam int unsigned CW = 32;

    // Refuse phase lengths the sequencer cannot serve
    if (STARTUP_CYCLES < 1 || OPERATE_CYCLES <= STARTUP_CYCLES + 2 || STANDBY_CYCLES < 1)
    begin : g_bad_cfg
        $error("hsw_field_switch: phase lengths cannot be served");
    end

    hsw_phase_t phase_q;
    logic [CW-1:0] cnt_q;
    logic strap_q;
    logic south_on_q;
    logic north_on_q;
    logic on_q;
    logic [1:0] valid_cnt_q;
    logic late_q;
    logic [CW-1:0] up_cnt_q;
    logic phase_end;
    logic [7:0] thr_op;
    logic [7:0] thr_rel;

    assign phase_end = (phase_q == HSW_NORTH) && (cnt_q == CW'(OPERATE_CYCLES - 1));

    // Field detect band: set at the upper level, clear below the lower one.
    // The strap only inverts the pin sense, so both levels stay fixed for
    // either strap setting; swapping the compare levels here would lose the band.
    assign thr_op = THR_HIGH;
    assign thr_rel = THR_LOW;

    // Strap follows the pin until the first decision, then moves with decisions
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            strap_q <= 1'b1;
        else if (phase_end || valid_cnt_q == 2'h0)
            strap_q <= i_polarity_strap;
    end

    // Phase sequencer
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            phase_q <= HSW_STARTUP;
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_q + CW'(1);
            unique case (phase_q)
                HSW_STANDBY:
                    if (cnt_q == CW'(STANDBY_CYCLES - 1))
                    begin
                        phase_q <= HSW_STARTUP;
                        cnt_q <= '0;
                    end
                HSW_STARTUP:
                    if (cnt_q == CW'(STARTUP_CYCLES - 1))
                        phase_q <= HSW_SOUTH;
                HSW_SOUTH:
                    phase_q <= HSW_NORTH;
                HSW_NORTH:
                    if (phase_end)
                    begin
                        phase_q <= HSW_STANDBY;
                        cnt_q <= '0;
                    end
            endcase
        end
    end

    // Sequential threshold checks with hysteresis
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            south_on_q <= 1'b0;
            north_on_q <= 1'b0;
        end
        else if (phase_q == HSW_SOUTH)
        begin
            if (i_south_field >= thr_op)
                south_on_q <= 1'b1;
            else if (i_south_field < thr_rel)
                south_on_q <= 1'b0;
            else
                south_on_q <= on_q;
        end
        else if (phase_q == HSW_NORTH && cnt_q == CW'(STARTUP_CYCLES + 1))
        begin
            if (i_north_field >= thr_op)
                north_on_q <= 1'b1;
            else if (i_north_field < thr_rel)
                north_on_q <= 1'b0;
            else
                north_on_q <= on_q;
        end
    end

    // Supply rise timing decides first valid phase
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            up_cnt_q <= '0;
            late_q <= 1'b0;
        end
        else if (!i_supply_ok && !late_q)
        begin
            up_cnt_q <= up_cnt_q + CW'(1);
            if (up_cnt_q >= CW'(STARTUP_WIN_CYCLES))
                late_q <= 1'b1;
        end
    end

    // Latched decision, taken only at operating phase end
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            on_q <= 1'b0;
            valid_cnt_q <= 2'h0;
        end
        else if (phase_end)
        begin
            on_q <= south_on_q || north_on_q;
            if (valid_cnt_q != 2'h2)
                valid_cnt_q <= valid_cnt_q + 2'h1;
        end
    end

    // Registered pin outputs
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_out_oe <= 1'b0;
            o_out_level <= 1'b1;
            o_out_valid <= 1'b0;
            o_sensing <= 1'b0;
        end
        else
        begin
            // Strap high: on pulls low; strap low: off pulls low
            o_out_oe <= strap_q ? on_q : !on_q;
            o_out_level <= strap_q ? !on_q : on_q;
            o_out_valid <= (valid_cnt_q >= (late_q ? 2'h2 : 2'h1));
            o_sensing <= (phase_q != HSW_STANDBY);
        end
    end

    // Start-up tail, then the south and the north check on the two cycles after it
    sequence startup_end_s;
        phase_q == HSW_STARTUP && cnt_q == CW'(STARTUP_CYCLES - 1);
    endsequence

    sequence pole_checks_s;
        (phase_q == HSW_SOUTH) ##1 (phase_q == HSW_NORTH && cnt_q == CW'(STARTUP_CYCLES + 1));
    endsequence

    // Output decision does not change on the cycle after the south check
    out_stable_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (phase_q == HSW_SOUTH) |=> $stable(on_q))
        else $error("output decision changed mid phase");

    // Standby holds the latched value
    standby_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (phase_q == HSW_STANDBY && $past(phase_q) == HSW_STANDBY) |-> $stable(on_q))
        else $error("output moved during standby");

    // After the first decision, the pin moves only on the cycle after a decision
    out_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        ($past(valid_cnt_q, 2) != 2'h0 && !$past(phase_end, 2)) |-> $stable(o_out_oe))
        else $error("output pin changed outside a decision");

    // Phase end enters standby
    phase_to_stby_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        phase_end |=> phase_q == HSW_STANDBY)
        else $error("standby not entered after operating phase");

    // Pole checks follow start-up
    startup_seq_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        startup_end_s |=> pole_checks_s)
        else $error("pole checks did not follow start-up");

    // Either pole operates
    omni_on_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (phase_end && (south_on_q || north_on_q)) |=> on_q)
        else $error("pole field did not operate switch");

    // High output level never enables the pull-down
    off_no_sink_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_out_level |-> !o_out_oe)
        else $error("pull-down on in high state");

    // Strap high: on drives low
    strap_high_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (strap_q && on_q && $stable(strap_q)) |=> !o_out_level)
        else $error("strap high polarity wrong");

    // Strap low: on releases high
    strap_low_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!strap_q && on_q && $stable(strap_q)) |=> o_out_level)
        else $error("strap low polarity wrong");

    // No valid output before the first decision
    valid_first_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (valid_cnt_q == 2'h0) |=> !o_out_valid)
        else $error("output valid too early");

    // Late supply needs a second decision before valid
    late_valid_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (late_q && valid_cnt_q == 2'h1) |=> !o_out_valid)
        else $error("late supply output valid too early");
endmodule : hsw_field_switch
`default_nettype wire

// file: sim/hsw_pullup_host.sv
// Pull-up resistor model for the open-drain switch output
`default_nettype none
module hsw_pullup_host
(
    input wire logic i_out_oe, // Pull-down enable from the switch
    output logic o_pin         // Wire level seen by the host input
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up holds the wire high unless the pull-down conducts
    assign o_pin = i_out_oe ? 1'b0 : 1'b1;
endmodule : hsw_pullup_host
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the duty-cycled field switch
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import hsw_pkg::*;
    localparam int OP = 20;
    localparam int SB = 30;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic strap = 1'b1;
    logic supply = 1'b1;
    logic [7:0] south = 8'h00;
    logic [7:0] north = 8'h00;
    logic oe, level, valid, sensing, pin, valid_seen;
    bit in_sync;
    int err_count = 0;
    int cmp_count = 0;
    // Switch with shortened phases
    hsw_field_switch #(.OPERATE_CYCLES(OP), .STANDBY_CYCLES(SB), .STARTUP_CYCLES(3),
        .STARTUP_WIN_CYCLES(5)) dut_u (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_polarity_strap(strap), .i_supply_ok(supply), .i_south_field(south),
        .i_north_field(north), .o_out_oe(oe), .o_out_level(level), .o_out_valid(valid),
        .o_sensing(sensing));
    // Pull-up on the output pin
    hsw_pullup_host pu_u (.i_out_oe(oe), .o_pin(pin));
    // Clock, 20 ns period
    initial
    begin
        forever #10 i_core_clk = ~i_core_clk;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task give_verdict;
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // Reset for 16 cycles, optionally with a slow supply
    task do_reset(input logic late);
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        supply <= ~late;
        in_sync = 0;
        repeat (16) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        if (late)
        begin
            repeat (8) @(posedge i_core_clk);
            supply <= 1'b1;
        end
    endtask : do_reset
    // One standby then one operating phase; lengths, stability, outcome
    task phase(input logic [7:0] s, input logic [7:0] n, input logic exp, input bit chk);
        int cnt;
        logic l0;
        @(posedge i_core_clk);
        south <= s;
        north <= n;
        #1;
        cnt = 1;
        l0 = level;
        while (sensing !== 1'b1 && cnt < 200)
        begin
            @(posedge i_core_clk);
            #1;
            cnt++;
            if (chk && level !== l0) check(level, l0);
        end
        valid_seen = valid;
        if (in_sync && chk) check(cnt, SB);
        cnt = 0;
        while (sensing === 1'b1 && cnt < 200)
        begin
            if (chk && level !== l0) check(level, l0);
            @(posedge i_core_clk);
            #1;
            cnt++;
        end
        if (in_sync && chk) check(cnt, OP);
        if (chk) check({oe, level, pin}, {~exp, exp, exp});
        in_sync = 1;
    endtask : phase
    // Power-up with the strap low rests at the low zero-field level
    task strap_low_boot;
        @(posedge i_core_clk);
        strap <= 1'b0;
        do_reset(1'b0);
        repeat (4) @(posedge i_core_clk);
        #1;
        check({oe, level, pin}, 3'b100);
        check(valid, 1'b0);
    endtask : strap_low_boot
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge i_core_clk);
        err_count++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        do_reset(1'b0);
        phase(8'h00, 8'h00, 1'b1, 1);
        phase(8'h32, 8'h00, 1'b0, 1);
        check(valid_seen, 1'b1);
        phase(8'h00, 8'h28, 1'b0, 1);
        phase(8'h00, 8'h27, 1'b1, 1);
        phase(8'h00, 8'h32, 1'b0, 1);
        phase(8'h31, 8'h00, 1'b0, 1);
        phase(8'h00, 8'h00, 1'b1, 1);
        @(posedge i_core_clk);
        strap <= 1'b0;
        phase(8'h00, 8'h00, 1'b0, 0);
        phase(8'h00, 8'h00, 1'b0, 0);
        phase(8'h00, 8'h00, 1'b0, 1);
        phase(8'h00, 8'h32, 1'b1, 1);
        phase(8'h28, 8'h00, 1'b1, 1);
        phase(8'h27, 8'h00, 1'b0, 1);
        @(posedge i_core_clk);
        strap <= 1'b1;
        do_reset(1'b1);
        phase(8'h00, 8'h00, 1'b1, 0);
        phase(8'h00, 8'h00, 1'b1, 1);
        check(valid_seen, 1'b0);
        phase(8'h00, 8'h00, 1'b1, 1);
        check(valid_seen, 1'b1);
        strap_low_boot();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
